// [bench/pci_capture_unit_bench.sv]
// Purpose: Self-checking bench for the position capture unit.
// Assumes: Filter counts are the listed times at a 10 ns clock.
// Notes: Pulses one cycle short of the filter time must not capture.
`timescale 1ns/1ns
`default_nettype none

module pci_capture_unit_bench;
	import pci_pkg::*;
	logic clk_sys_i = 0;
	logic reset_n_i = 1;
	logic fire = 0;
	logic [10:0] width = '0;
	logic capture_in;
	logic signed [31:0] pos = '0;
	logic [7:0] opts = '0;
	logic [7:0] sub = '0;
	logic wr = 0;
	logic rd = 0;
	logic [31:0] wdata = '0;
	logic [31:0] rdata;
	logic rvalid;
	logic err;
	logic flag;
	int err_total = 0;
	int checks = 0;
	int cyc [10] = '{5, 15, 20, 30, 50, 90, 170, 330, 650, 1290};

	pci_capture_unit dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.capture_in_i(capture_in), .motor_position_i(pos),
		.unit_options_i(opts), .od_sub_index_i(sub), .od_write_i(wr),
		.od_read_i(rd), .od_wdata_i(wdata), .od_rdata_o(rdata),
		.od_rvalid_o(rvalid), .od_error_o(err), .capture_flag_o(flag));
	pci_trigger_model trig (.clk_sys_i(clk_sys_i), .fire_i(fire),
		.width_i(width), .capture_in_o(capture_in));

	initial
	begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [7:0] s,
		input logic [31:0] d, input logic [31:0] exp, input logic e);
		@(posedge clk_sys_i);
		#1;
		sub = s;
		wr = w;
		rd = !w;
		wdata = d;
		@(posedge clk_sys_i);
		#1;
		wr = 0;
		rd = 0;
		chk({31'h0, rvalid}, 32'h1);
		chk(rdata, exp);
		chk({31'h0, err}, {31'h0, e});
	endtask : acc

	// Settling time covers the filter on both edges of the pulse.
	task automatic pulse(input int n);
		@(posedge clk_sys_i);
		#1;
		width = n[10:0];
		fire = 1;
		@(posedge clk_sys_i);
		#1;
		fire = 0;
		repeat (2 * n + 10) @(posedge clk_sys_i);
		#1;
	endtask : pulse

	task automatic t_reset();
		acc(0, SUB_ENTRY_COUNT, 0, 32'h04, 0);
		acc(0, SUB_ENABLE, 0, 32'h00, 0);
		acc(0, SUB_FLAG, 0, 32'h00, 0);
		acc(0, SUB_FILTER, 0, 32'h00, 0);
		acc(0, SUB_POSITION, 0, 32'h00, 0);
		acc(0, 8'h05, 0, 32'h00, 1);
		chk({31'h0, flag}, 32'h0);
	endtask : t_reset

	task automatic t_refuse();
		acc(1, SUB_ENABLE, 32'h2, 32'h0, 1);
		acc(1, SUB_FILTER, 32'hA, 32'h0, 1);
		acc(1, SUB_POSITION, 32'h5, 32'h0, 1);
		acc(0, SUB_FILTER, 0, 32'h0, 0);
		acc(0, SUB_POSITION, 0, 32'h0, 0);
	endtask : t_refuse

	task automatic t_gate();
		pos = 32'h0000_0077;
		pulse(6);
		chk({31'h0, flag}, 32'h0);
		acc(1, SUB_ENABLE, 32'h1, 32'h0, 0);
		opts = 8'h04;
		pulse(6);
		chk({31'h0, flag}, 32'h0);
		opts = 8'h00;
		acc(0, SUB_POSITION, 0, 32'h0, 0);
	endtask : t_gate

	task automatic t_filter();
		for (int c = 0; c < 10; c++)
		begin
			acc(1, SUB_FILTER, c, 32'h0, 0);
			acc(0, SUB_FILTER, 0, c, 0);
			pos = 32'hFFFF_FF00 - c;
			pulse(cyc[c] - 1);
			chk({31'h0, flag}, 32'h0);
			pulse(cyc[c]);
			chk({31'h0, flag}, 32'h1);
			acc(0, SUB_FLAG, 0, 32'h01, 0);
			acc(0, SUB_POSITION, 0, 32'hFFFF_FF00 - c, 0);
			acc(1, SUB_FLAG, 32'h01, 32'h0, 0);
			chk({31'h0, flag}, 32'h1);
			acc(1, SUB_FLAG, 32'hFF, 32'h0, 0);
			chk({31'h0, flag}, 32'h0);
		end
	endtask : t_filter

	// A reset in mid-run must wipe a capture already taken.
	task automatic t_rerun();
		acc(1, SUB_FILTER, 32'h0, 32'h0, 0);
		pos = 32'h1234_5678;
		pulse(5);
		chk({31'h0, flag}, 32'h1);
		acc(0, SUB_POSITION, 0, 32'h1234_5678, 0);
		reset_n_i = 0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		reset_n_i = 1;
		repeat (3) @(posedge clk_sys_i);
		chk({31'h0, flag}, 32'h0);
		acc(0, SUB_FLAG, 0, 32'h00, 0);
		acc(0, SUB_POSITION, 0, 32'h00, 0);
		acc(0, SUB_ENABLE, 0, 32'h00, 0);
	endtask : t_rerun

	task automatic close_out();
		$display("errors=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// A real falling edge before the first clock clears every flop of the capture unit.
	initial
	begin
		#1;
		reset_n_i = 0;
		repeat (10) @(posedge clk_sys_i);
		#1;
		reset_n_i = 1;
		repeat (3) @(posedge clk_sys_i);
		t_reset();
		t_refuse();
		t_gate();
		t_filter();
		t_rerun();
		close_out();
	end

	// Whole run needs about 11000 cycles; this allows ample margin.
	initial
	begin
		#600000;
		err_total++;
		close_out();
	end
endmodule : pci_capture_unit_bench

`default_nettype wire

// [bench/pci_trigger_model.sv]
// Purpose: Far-side source of the capture input pulses.
// Assumes: Pulses are launched by a one-cycle fire request.
// Notes: The line idles low, as a pulled-down trigger input would.
`timescale 1ns/1ns
`default_nettype none

module pci_trigger_model
(
	input wire logic clk_sys_i,
	input wire logic fire_i,
	input wire logic [10:0] width_i,
	output logic capture_in_o
);
	logic [10:0] left = '0;

	// The pulse stays high for exactly width_i sampling edges.
	always_ff @(posedge clk_sys_i)
	begin
		if (fire_i)
			left <= width_i;
		else if (left != 11'h000)
			left <= left - 11'h001;
	end

	assign capture_in_o = (left != 11'h000);
endmodule : pci_trigger_model

`default_nettype wire

// [logic/pci_capture_unit.sv]
// Purpose: Position capture on a filtered external input.
// Assumes: Inputs synchronous to clk_sys_i; object access one word per strobe.
// Notes: Captures on the rising edge of the filtered input.
//
// Overview of operation
// R1 - Enable setting 0 or 1, resets disabled
// R2 - Capture also needs pin chosen for capture
// R3 - Capture sets flag bit zero, sticky
// R4 - Writing all ones clears the flag
// R5 - Filter code 0 to 9 picks time
// R6 - Signed 32-bit captured position, read only
// R7 - Flag reads zero after reset
// R8 - Unit option bit two selects pin role
// R9 - Stable filtered edge latches position and flag
`timescale 1ns/1ns
`default_nettype none

module pci_capture_unit
	import pci_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic capture_in_i,
	input wire logic signed [31:0] motor_position_i,
	input wire logic [7:0] unit_options_i,
	input wire logic [7:0] od_sub_index_i,
	input wire logic od_write_i,
	input wire logic od_read_i,
	input wire logic [31:0] od_wdata_i,
	output logic [31:0] od_rdata_o,
	output logic od_rvalid_o,
	output logic od_error_o,
	output logic capture_flag_o
);

	logic rst_meta;
	logic rst_n;
	logic [7:0] capture_enable_ctrl;
	logic [7:0] capture_event_flag;
	logic [7:0] capture_filter_select;
	logic signed [31:0] captured_position_value;
	logic filt_level;
	logic filt_level_d;
	logic pin_is_capture;
	logic capture_hit;
	logic flag_clear;
	logic wr_enable;
	logic wr_filter;
	logic [31:0] next_rdata;
	logic next_error;

	// Release of reset is synchronised; assertion stays asynchronous.
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	pci_input_filter u_filter (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n),
		.raw_i(capture_in_i),
		.limit_i(filter_cycles(capture_filter_select)), // [R5]
		.level_o(filt_level)
	);

	assign pin_is_capture = !unit_options_i[UNIT_OPT_TRIP_BIT]; // [R8]
	assign capture_hit = filt_level && !filt_level_d
		&& (capture_enable_ctrl == ENABLE_MAX) // [R1]
		&& pin_is_capture; // [R2]
	assign flag_clear = od_write_i && (od_sub_index_i == SUB_FLAG)
		&& (od_wdata_i[7:0] == FLAG_CLEAR_VALUE); // [R4]
	// Out-of-range values are refused so the settings never hold junk.
	assign wr_enable = od_write_i && (od_sub_index_i == SUB_ENABLE)
		&& (od_wdata_i <= 32'(ENABLE_MAX));
	assign wr_filter = od_write_i && (od_sub_index_i == SUB_FILTER)
		&& (od_wdata_i <= 32'(FILTER_CODE_MAX));

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_level_d <= 1'b0;
		end
		else
		begin
			filt_level_d <= filt_level;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			capture_enable_ctrl <= ENABLE_RESET; // [R1]
			capture_filter_select <= FILTER_RESET; // [R5]
		end
		else
		begin
			if (wr_enable)
			begin
				capture_enable_ctrl <= od_wdata_i[7:0]; // [R1]
			end
			if (wr_filter)
			begin
				capture_filter_select <= od_wdata_i[7:0]; // [R5]
			end
		end
	end

	// A capture in the same cycle as a clear wins, so no event is lost.
	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			capture_event_flag <= FLAG_RESET; // [R7]
		end
		else if (capture_hit)
		begin
			capture_event_flag <= FLAG_SET_VALUE; // [R3] [R9]
		end
		else if (flag_clear)
		begin
			capture_event_flag <= FLAG_RESET; // [R4]
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			captured_position_value <= POSITION_RESET; // [R6]
		end
		else if (capture_hit)
		begin
			captured_position_value <= motor_position_i; // [R6] [R9]
		end
	end

	always_comb
	begin
		next_rdata = '0;
		next_error = 1'b0;
		case (od_sub_index_i)
			SUB_ENTRY_COUNT: next_rdata = {24'h00_0000, ENTRY_COUNT_VALUE};
			SUB_ENABLE: next_rdata = {24'h00_0000, capture_enable_ctrl};
			SUB_FLAG: next_rdata = {24'h00_0000, capture_event_flag};
			SUB_FILTER: next_rdata = {24'h00_0000, capture_filter_select};
			SUB_POSITION: next_rdata = captured_position_value;
			default: next_error = 1'b1;
		endcase
		if (od_write_i)
		begin
			next_rdata = '0;
			next_error = !(wr_enable || wr_filter
				|| (od_sub_index_i == SUB_FLAG)); // [R6]
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			od_rdata_o <= '0;
			od_rvalid_o <= 1'b0;
			od_error_o <= 1'b0;
		end
		else
		begin
			od_rdata_o <= (od_read_i && !od_write_i) ? next_rdata : '0;
			od_rvalid_o <= od_read_i || od_write_i;
			od_error_o <= (od_read_i || od_write_i) && next_error;
		end
	end

	assign capture_flag_o = capture_event_flag[0];

	a_capture_gated: assert property ( // [R1] [R2] [R8]
		@(posedge clk_sys_i) disable iff (!rst_n)
		$rose(capture_event_flag[0]) |-> $past(capture_enable_ctrl) == 8'h01
		&& !$past(unit_options_i[2]))
		else $error("Flag set while capture was not allowed.");

	a_enable_range: assert property ( // [R1]
		@(posedge clk_sys_i) disable iff (!rst_n)
		capture_enable_ctrl <= 8'h01)
		else $error("Capture enable holds a value other than 0 or 1.");

	a_flag_sets: assert property ( // [R3] [R9]
		@(posedge clk_sys_i) disable iff (!rst_n)
		(filt_level && !filt_level_d && capture_enable_ctrl == 8'h01
		&& !unit_options_i[2]) |=> capture_event_flag == 8'h01)
		else $error("Accepted edge did not set the flag.");

	a_flag_sticky: assert property ( // [R3]
		@(posedge clk_sys_i) disable iff (!rst_n)
		(capture_event_flag[0] && !(od_write_i && od_sub_index_i == 8'h02))
		|=> capture_event_flag[0])
		else $error("Flag dropped without a clearing write.");

	a_flag_clear: assert property ( // [R4]
		@(posedge clk_sys_i) disable iff (!rst_n)
		(od_write_i && od_sub_index_i == 8'h02 && od_wdata_i[7:0] == 8'hFF
		&& !capture_hit) |=> capture_event_flag == 8'h00)
		else $error("All-ones write did not clear the flag.");

	a_filter_range: assert property ( // [R5]
		@(posedge clk_sys_i) disable iff (!rst_n)
		capture_filter_select <= 8'h09)
		else $error("Filter code out of range.");

	a_position_latch: assert property ( // [R6] [R9]
		@(posedge clk_sys_i) disable iff (!rst_n)
		capture_hit |=> captured_position_value == $past(motor_position_i))
		else $error("Position not latched on capture.");

	a_position_hold: assert property ( // [R6]
		@(posedge clk_sys_i) disable iff (!rst_n)
		!capture_hit |=> $stable(captured_position_value))
		else $error("Captured position changed without a capture.");

	a_flag_reset: assert property ( // [R7]
		@(posedge clk_sys_i)
		$rose(rst_n) |-> capture_event_flag == 8'h00
		&& captured_position_value == 32'h0000_0000)
		else $error("Flag or position not zero after reset.");

endmodule : pci_capture_unit

`default_nettype wire

// [logic/pci_input_filter.sv]
// Purpose: Glitch filter for the capture input.
// Assumes: Raw input is synchronous to the clock.
// Notes: A new level is accepted after limit_i cycles of difference.
`timescale 1ns/1ns
`default_nettype none

module pci_input_filter
	import pci_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic raw_i,
	input wire logic [pci_pkg::FILT_CNT_W-1:0] limit_i,
	output logic level_o
);

	logic [FILT_CNT_W-1:0] diff_count;

	// Any return to the held level restarts the wait, so short glitches vanish.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			level_o <= 1'b0;
			diff_count <= '0;
		end
		else if (raw_i == level_o)
		begin
			diff_count <= '0;
		end
		else if (diff_count >= limit_i - 1'b1)
		begin
			level_o <= raw_i; // [R9]
			diff_count <= '0;
		end
		else
		begin
			diff_count <= diff_count + 1'b1;
		end
	end

	a_filter_wait: assert property ( // [R9]
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$changed(level_o) |-> ($past(diff_count) == $past(limit_i) - 1'b1)
		&& ($past(raw_i) != $past(level_o)))
		else $error("Filter accepted a level before its wait ended.");

endmodule : pci_input_filter

`default_nettype wire

// [logic/pci_pkg.sv]
// Purpose: Shared constants for the position capture input unit.
// Assumes: System clock of 100 MHz.
// Notes: Register offsets are the object sub-index numbers.
`default_nettype none

package pci_pkg;

	localparam logic [7:0] SUB_ENTRY_COUNT = 8'h00;
	localparam logic [7:0] SUB_ENABLE = 8'h01;
	localparam logic [7:0] SUB_FLAG = 8'h02;
	localparam logic [7:0] SUB_FILTER = 8'h03;
	localparam logic [7:0] SUB_POSITION = 8'h04;

	localparam logic [7:0] ENTRY_COUNT_VALUE = 8'h04;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_MAX = 8'h01;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] FLAG_SET_VALUE = 8'h01;
	localparam logic [7:0] FLAG_CLEAR_VALUE = 8'hFF;
	localparam logic [7:0] FILTER_RESET = 8'h00;
	localparam logic [7:0] FILTER_CODE_MAX = 8'h09;
	localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
	localparam int UNIT_OPT_TRIP_BIT = 2;

	localparam int CLK_PERIOD_NS = 10;
	localparam int FILT_CNT_W = 11;
	localparam int FILTER_NS [10] = '{50, 150, 200, 300, 500, 900, 1700,
		3300, 6500, 12900};

	// Least times round up to whole cycles, never below one.
	function automatic logic [FILT_CNT_W-1:0] filter_cycles(
		input logic [7:0] code);
		int ns;
		int cyc;
		ns = FILTER_NS[(code > FILTER_CODE_MAX) ? 0 : int'(code)];
		cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		if (cyc < 1)
		begin
			cyc = 1;
		end
		return cyc[FILT_CNT_W-1:0];
	endfunction : filter_cycles

endpackage : pci_pkg

`default_nettype wire
